//--- hdl/tcc_defines.vh
`ifndef TCC_DEFINES_VH
`define TCC_DEFINES_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define TCC_ADDR_CTRL_A   12'h000
`define TCC_ADDR_CTRL_B   12'h004
`define TCC_ADDR_COUNT    12'h008
`define TCC_ADDR_CMP_A    12'h00c
`define TCC_ADDR_CMP_B    12'h010
`define TCC_ADDR_MASK     12'h014
`define TCC_ADDR_FLAG     12'h018
`define TCC_ADDR_ACK      12'h01c
// ----------------------------------------
// Field positions
// ----------------------------------------
`define TCC_A_WGM0        0
`define TCC_A_WGM1        1
`define TCC_A_COMB_LO     4
`define TCC_A_COMA_LO     6
`define TCC_B_CS_LO       0
`define TCC_B_WGM2        3
`define TCC_B_FOCB        6
`define TCC_B_FOCA        7
`define TCC_F_OVF         0
`define TCC_F_CMPA        1
`define TCC_F_CMPB        2
// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define TCC_RST_BYTE      8'h00
`define TCC_BOTTOM        8'h00
`define TCC_MAX           8'hff
`define TCC_CS_STOP       3'h0
`define TCC_CS_DIV1       3'h1
`define TCC_CS_DIV8       3'h2
`define TCC_CS_DIV64      3'h3
`define TCC_CS_DIV256     3'h4
`define TCC_CS_DIV1024    3'h5
`define TCC_CS_EXT_FALL   3'h6
`define TCC_WGM_NORMAL    3'h0
`define TCC_WGM_PC_FF     3'h1
`define TCC_WGM_CTC       3'h2
`define TCC_WGM_FAST_FF   3'h3
`define TCC_WGM_PC_OCA    3'h5
`define TCC_WGM_FAST_OCA  3'h7
`endif

//--- hdl/tcc_tick_gen.v
`include "tcc_defines.vh"
module tcc_tick_gen
(
  // Clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // Control
  input  wire [2:0] clock_source_select,
  input  wire       external_count_pin,
  // Tick
  output reg        timer_tick
);
  reg  [9:0] pre_r;
  reg        sync1_r;
  reg        sync2_r;
  reg        sync3_r;
  wire       rise;
  wire       fall;
  assign rise = sync2_r & ~sync3_r;
  assign fall = ~sync2_r & sync3_r;
  // ----------------------------------------
  // Prescaler and pin synchroniser
  // ----------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_r   <= 10'h000;
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end
    else
    begin
      pre_r   <= pre_r + 10'h001;
      sync1_r <= external_count_pin;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end
  // Source and edge select; a stopped selection gives no tick at all
  always @*
  begin
    case (clock_source_select)
      `TCC_CS_STOP:     timer_tick = 1'b0; // [R3]
      `TCC_CS_DIV1:     timer_tick = 1'b1; // [R2]
      `TCC_CS_DIV8:     timer_tick = (pre_r[2:0] == 3'h7);
      `TCC_CS_DIV64:    timer_tick = (pre_r[5:0] == 6'h3f);
      `TCC_CS_DIV256:   timer_tick = (pre_r[7:0] == 8'hff);
      `TCC_CS_DIV1024:  timer_tick = (pre_r == 10'h3ff);
      `TCC_CS_EXT_FALL: timer_tick = fall; // [R2]
      default:          timer_tick = rise;
    endcase
  end
endmodule

//--- hdl/tcc_timer8.v
// ----------------------------------------
// Contract
// [R1] Counter and both compare values are 8-bit software read/write registers.
// [R2] Tick comes from prescaler or external pin, source and edge selectable.
// [R3] Clock source select zero gives no tick; counter stays stopped.
// [R4] Each tick clears, increments or decrements counter per mode.
// [R5] Counter readable and writable whether or not ticks run.
// [R6] Software counter write wins over a coincident clear or count.
// [R7] Three-bit mode select: two bits in control A, one in B.
// [R8] Bottom flagged at 0x00, maximum at 0xff.
// [R9] TOP is 0xff or compare value A depending on mode.
// [R10] Overflow flag set per mode and can request interrupt.
// [R11] Counter equal to compare value sets compare flag next tick.
// [R12] All requests visible in flag register, each masked individually.
// [R13] Compare flag clears automatically when its interrupt is serviced.
// [R14] Writing one to a flag bit clears it.
// [R15] Compare values double buffered in PWM modes only.
// [R16] Buffered value transfers only at top or bottom.
// [R17] Software compare access goes to buffer when buffering, else direct.
// [R18] Force strobe acts as match on output only, non-PWM modes.
// [R19] Counter write blocks compare matches on the next tick, even stopped.
// [R20] Compare output state kept across mode changes.
// [R21] Compare output action bits take effect at once.
// [R22] Software avoids writing bottom while down-counting; sets output first.
// [R23] Compare output states reset to zero.
// [R24] Action field zero leaves compare output unchanged on match.
// [R25] Normal mode counts up, wraps, sets overflow when reaching zero.
// ----------------------------------------
//
// Implementation choices: the register offsets and the APB slave port.
`include "tcc_defines.vh"
module tcc_timer8
(
  // APB slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // Pins
  input  wire        external_count_pin,
  output wire        compare_output_a,
  output wire        compare_output_b,
  // Interrupt service
  output wire        irq_overflow,
  output wire        irq_compare_a,
  output wire        irq_compare_b,
  input  wire        ack_overflow,
  input  wire        ack_compare_a,
  input  wire        ack_compare_b
);
  reg  [7:0] timer_control_a_r;
  reg  [7:0] timer_control_b_r;
  reg  [7:0] timer_count_value_r;
  reg  [7:0] compare_value_a_r;
  reg  [7:0] compare_value_b_r;
  reg  [7:0] buf_a_r;
  reg  [7:0] buf_b_r;
  reg  [2:0] timer_mask_register_r;
  reg  [2:0] timer_flag_register_r;
  reg        up_r;
  reg        block_r;
  reg        match_a_r;
  reg        match_b_r;
  reg  [1:0] oc_r;
  reg  [7:0] cnt_nxt;
  reg        up_nxt;
  reg  [1:0] oc_nxt;
  reg        ovf_hit;
  reg  [31:0] prdata_nxt;
  wire       timer_tick;
  wire [2:0] waveform_generation_select;
  wire [1:0] act_a;
  wire [1:0] act_b;
  wire       pwm;
  wire       dual;
  wire [7:0] top;
  wire       wr;
  wire       rd_ok;
  wire       wr_cnt;
  wire       at_top;
  wire       at_bot;
  wire       is_bot;
  wire       is_max;
  wire       ovf_set;
  wire       eq_a;
  wire       eq_b;
  wire       force_a;
  wire       force_b;
  wire [2:0] clr_mask;
  wire [2:0] ack_vec;
  wire [1:0] step_a;
  wire [1:0] step_b;
  // ----------------------------------------
  // Decode
  // ----------------------------------------
  function [1:0] oc_step;
    input [1:0] act;
    input       cur;
    input       is_pwm;
    input       slope_up;
    begin
      oc_step = {1'b0, cur};
      if (act == 2'b00)
        oc_step = {1'b0, cur}; // [R24]
      else if (!is_pwm)
        oc_step = (act == 2'b01) ? {1'b1, ~cur} : {1'b1, act[0]};
      else if (act[1])
        oc_step = {1'b1, act[0] ^ ~slope_up};
    end
  endfunction
  function is_reg;
    input [11:0] a;
    input [11:0] r;
    begin
      is_reg = (a == r);
    end
  endfunction
  assign waveform_generation_select = {timer_control_b_r[`TCC_B_WGM2],
                                       timer_control_a_r[`TCC_A_WGM1],
                                       timer_control_a_r[`TCC_A_WGM0]}; // [R7]
  assign act_a = timer_control_a_r[`TCC_A_COMA_LO +: 2]; // [R21]
  assign act_b = timer_control_a_r[`TCC_A_COMB_LO +: 2]; // [R21]
  assign pwm  = waveform_generation_select[0]; // [R15]
  assign dual = waveform_generation_select[0] & ~waveform_generation_select[1];
  assign top  = (waveform_generation_select[2] | (waveform_generation_select == `TCC_WGM_CTC))
                ? compare_value_a_r : `TCC_MAX; // [R9]
  assign is_bot = (timer_count_value_r == `TCC_BOTTOM); // [R8]
  assign is_max = (timer_count_value_r == `TCC_MAX); // [R8]
  assign at_top = (timer_count_value_r == top);
  assign at_bot = is_bot;
  assign wr     = psel & penable & pwrite;
  assign wr_cnt = wr & is_reg(paddr, `TCC_ADDR_COUNT);
  assign pready = 1'b1;
  assign rd_ok  = (paddr <= `TCC_ADDR_ACK) & (paddr[1:0] == 2'b00);
  assign pslverr = psel & penable & ~rd_ok;
  assign eq_a = (timer_count_value_r == compare_value_a_r); // [R11]
  assign eq_b = (timer_count_value_r == compare_value_b_r); // [R11]
  assign force_a = wr & is_reg(paddr, `TCC_ADDR_CTRL_B) & pwdata[`TCC_B_FOCA] & ~pwm; // [R18]
  assign force_b = wr & is_reg(paddr, `TCC_ADDR_CTRL_B) & pwdata[`TCC_B_FOCB] & ~pwm; // [R18]
  assign ovf_set = timer_tick & ~wr_cnt & ovf_hit; // [R10]
  assign clr_mask = (wr & is_reg(paddr, `TCC_ADDR_FLAG)) ? pwdata[2:0] : 3'b000; // [R14]
  assign ack_vec  = {ack_compare_b, ack_compare_a, ack_overflow}; // [R13]
  assign irq_overflow  = timer_flag_register_r[`TCC_F_OVF]  & timer_mask_register_r[0]; // [R12]
  assign irq_compare_a = timer_flag_register_r[`TCC_F_CMPA] & timer_mask_register_r[1]; // [R12]
  assign irq_compare_b = timer_flag_register_r[`TCC_F_CMPB] & timer_mask_register_r[2]; // [R12]
  assign compare_output_a = oc_r[0];
  assign compare_output_b = oc_r[1];
  assign step_a = oc_step(act_a, oc_r[0], pwm, up_r);
  assign step_b = oc_step(act_b, oc_r[1], pwm, up_r);
  tcc_tick_gen u_tick
  (
    .pclk                (pclk),
    .presetn             (presetn),
    .clock_source_select (timer_control_b_r[`TCC_B_CS_LO +: 3]),
    .external_count_pin  (external_count_pin),
    .timer_tick          (timer_tick)
  );
  // ----------------------------------------
  // Counter next value
  // ----------------------------------------
  always @*
  begin
    cnt_nxt = timer_count_value_r;
    up_nxt  = up_r;
    if (wr_cnt)
      cnt_nxt = pwdata[7:0]; // [R6]
    else if (timer_tick)
    begin
      if (dual)
      begin
        if (up_r && at_top)
        begin
          up_nxt  = 1'b0;
          cnt_nxt = timer_count_value_r - 8'h01; // [R4]
        end
        else if (!up_r && at_bot)
        begin
          up_nxt  = 1'b1;
          cnt_nxt = timer_count_value_r + 8'h01;
        end
        else
          cnt_nxt = up_r ? timer_count_value_r + 8'h01 : timer_count_value_r - 8'h01;
      end
      else if (waveform_generation_select != `TCC_WGM_NORMAL && at_top)
        cnt_nxt = `TCC_BOTTOM; // [R4]
      else
        cnt_nxt = timer_count_value_r + 8'h01; // [R25]
      if (!dual)
        up_nxt = 1'b1;
    end
  end
  // ----------------------------------------
  // Overflow point
  // ----------------------------------------
  // Wrap at MAX in normal and clear-on-match, TOP in fast PWM, BOTTOM in phase correct;
  // reserved codes fall back to the MAX wrap so a stray mode still reports overflow
  always @*
  begin
    case (waveform_generation_select)
      `TCC_WGM_PC_FF,
      `TCC_WGM_PC_OCA:   ovf_hit = is_bot;
      `TCC_WGM_FAST_FF,
      `TCC_WGM_FAST_OCA: ovf_hit = at_top;
      default:           ovf_hit = is_max; // [R8]
    endcase
  end
  // ----------------------------------------
  // Output waveform state
  // ----------------------------------------
  // The mode field never touches it directly
  always @*
  begin
    oc_nxt = oc_r; // [R20]
    if ((timer_tick && match_a_r && !block_r) || force_a)
      oc_nxt[0] = step_a[1] ? step_a[0] : oc_r[0];
    if ((timer_tick && match_b_r && !block_r) || force_b)
      oc_nxt[1] = step_b[1] ? step_b[0] : oc_r[1];
    if (timer_tick && pwm && !dual && at_top)
    begin
      if (act_a[1])
        oc_nxt[0] = ~act_a[0];
      if (act_b[1])
        oc_nxt[1] = ~act_b[0];
    end
  end
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_control_a_r     <= `TCC_RST_BYTE;
      timer_control_b_r     <= `TCC_RST_BYTE;
      timer_count_value_r   <= `TCC_RST_BYTE;
      compare_value_a_r     <= `TCC_RST_BYTE;
      compare_value_b_r     <= `TCC_RST_BYTE;
      buf_a_r               <= `TCC_RST_BYTE;
      buf_b_r               <= `TCC_RST_BYTE;
      timer_mask_register_r <= 3'b000;
      timer_flag_register_r <= 3'b000;
      up_r                  <= 1'b1;
      oc_r                  <= 2'b00; // [R23]
    end
    else
    begin
      timer_count_value_r <= cnt_nxt; // [R5]
      up_r                <= up_nxt;
      oc_r                <= oc_nxt;
      // Set wins over software clear and interrupt acknowledge
      timer_flag_register_r[`TCC_F_OVF] <= ovf_set |
        (timer_flag_register_r[`TCC_F_OVF] & ~clr_mask[0] & ~ack_vec[0]);
      timer_flag_register_r[`TCC_F_CMPA] <= (timer_tick & match_a_r & ~block_r) |
        (timer_flag_register_r[`TCC_F_CMPA] & ~clr_mask[1] & ~ack_vec[1]); // [R11]
      timer_flag_register_r[`TCC_F_CMPB] <= (timer_tick & match_b_r & ~block_r) |
        (timer_flag_register_r[`TCC_F_CMPB] & ~clr_mask[2] & ~ack_vec[2]); // [R13]
      if (wr && is_reg(paddr, `TCC_ADDR_CTRL_A))
        timer_control_a_r <= pwdata[7:0];
      if (wr && is_reg(paddr, `TCC_ADDR_CTRL_B))
        timer_control_b_r <= {2'b00, pwdata[5:0]};
      if (wr && is_reg(paddr, `TCC_ADDR_MASK))
        timer_mask_register_r <= pwdata[2:0];
      if (wr && is_reg(paddr, `TCC_ADDR_CMP_A))
        buf_a_r <= pwdata[7:0]; // [R17]
      if (wr && is_reg(paddr, `TCC_ADDR_CMP_B))
        buf_b_r <= pwdata[7:0]; // [R17]
      if (!pwm)
      begin
        // Direct access: buffer mirrors the active value
        if (wr && is_reg(paddr, `TCC_ADDR_CMP_A))
          compare_value_a_r <= pwdata[7:0]; // [R15]
        if (wr && is_reg(paddr, `TCC_ADDR_CMP_B))
          compare_value_b_r <= pwdata[7:0];
      end
      else if (timer_tick && (dual ? at_top : at_bot))
      begin
        compare_value_a_r <= buf_a_r; // [R16]
        compare_value_b_r <= buf_b_r; // [R16]
      end
    end
  end
  // ----------------------------------------
  // Compare match pipeline
  // ----------------------------------------
  // A match is held from the tick that saw it to the next tick, which sets the flag;
  // the one-tick delay is what lets a counter write block it in between
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      block_r   <= 1'b0;
      match_a_r <= 1'b0;
      match_b_r <= 1'b0;
    end
    else
    begin
      // Block holds until the next tick has passed, even when stopped
      if (wr_cnt)
        block_r <= 1'b1; // [R19]
      else if (timer_tick)
        block_r <= 1'b0; // [R19]
      if (timer_tick)
      begin
        match_a_r <= eq_a & ~block_r & ~wr_cnt; // [R19]
        match_b_r <= eq_b & ~block_r & ~wr_cnt;
      end
    end
  end
  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Captured in the setup phase so the data output comes from a flip-flop;
  // the access phase therefore returns the value as it stood one cycle earlier
  always @*
  begin
    prdata_nxt = 32'h00000000;
    case (paddr)
      `TCC_ADDR_CTRL_A: prdata_nxt = {24'h000000, timer_control_a_r};
      `TCC_ADDR_CTRL_B: prdata_nxt = {24'h000000, timer_control_b_r};
      `TCC_ADDR_COUNT:  prdata_nxt = {24'h000000, timer_count_value_r}; // [R1]
      `TCC_ADDR_CMP_A:  prdata_nxt = {24'h000000, pwm ? buf_a_r : compare_value_a_r}; // [R17]
      `TCC_ADDR_CMP_B:  prdata_nxt = {24'h000000, pwm ? buf_b_r : compare_value_b_r};
      `TCC_ADDR_MASK:   prdata_nxt = {29'h0, timer_mask_register_r};
      `TCC_ADDR_FLAG:   prdata_nxt = {29'h0, timer_flag_register_r};
      default:          prdata_nxt = 32'h00000000;
    endcase
  end
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable)
      prdata <= prdata_nxt; // [R1]
  end
endmodule

//--- test/tcc_timer8_sva.sv
module tcc_timer8_sva
(
  // Bus
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic        pready,
  input logic [31:0] prdata,
  input logic        pslverr,
  // Pins and requests
  input logic        compare_output_a,
  input logic        compare_output_b,
  input logic        irq_overflow,
  input logic        irq_compare_a,
  input logic        irq_compare_b
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic       acc;
  logic       bad;
  logic [2:0] mask_r;
  assign acc = psel && penable;
  assign bad = (paddr > 12'h01c) || (paddr[1:0] != 2'h0);
  // Shadow of the mask, since the flags behind the requests are not visible here
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      mask_r <= 3'h0;
    else if (acc && pwrite && paddr == 12'h014)
      mask_r <= pwdata[2:0];
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_ready_high: assert property (psel |-> pready)
    else $error("pready low");
  a_err_map: assert property (acc && bad |-> pslverr)
    else $error("no error on unmapped access");
  a_err_none: assert property (acc && !bad |-> !pslverr)
    else $error("error on mapped access");
  a_rd_unmapped: assert property (
    acc && !pwrite && (bad || paddr == 12'h01c) |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_rd_upper: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_strobe_zero: assert property (
    acc && !pwrite && paddr == 12'h004 |-> prdata[7:6] == 2'h0)
    else $error("force strobes read back");
  a_mask_rdbk: assert property (
    acc && !pwrite && paddr == 12'h014 |-> prdata[2:0] == mask_r)
    else $error("mask readback wrong");
  a_irq_masked: assert property (
    ({irq_compare_b, irq_compare_a, irq_overflow} & ~mask_r) == 3'h0)
    else $error("request passed a clear mask bit");
  a_reset_clear: assert property (
    $rose(presetn) |-> !compare_output_a && !compare_output_b
    && !irq_overflow && !irq_compare_a && !irq_compare_b)
    else $error("outputs not zero after reset");
  c_err: cover property (acc && bad);
  c_irq: cover property (irq_compare_a || irq_compare_b);
  c_oc: cover property ($rose(compare_output_a));
endmodule

bind tcc_timer8 tcc_timer8_sva u_sva
(
  .pclk             (pclk),
  .presetn          (presetn),
  .psel             (psel),
  .penable          (penable),
  .pwrite           (pwrite),
  .paddr            (paddr),
  .pwdata           (pwdata),
  .pready           (pready),
  .prdata           (prdata),
  .pslverr          (pslverr),
  .compare_output_a (compare_output_a),
  .compare_output_b (compare_output_b),
  .irq_overflow     (irq_overflow),
  .irq_compare_a    (irq_compare_a),
  .irq_compare_b    (irq_compare_b)
);

//--- test/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        ext_pin = 1'b0;
  logic [2:0]  ack = 3'h0;
  logic [31:0] rd;
  wire         pready;
  wire  [31:0] prdata;
  wire         pslverr;
  wire         oc_a;
  wire         oc_b;
  wire  [2:0]  irq;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  always #25 pclk = ~pclk;
  tcc_timer8 u_dut
  (
    .pclk               (pclk),
    .presetn            (presetn),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .pready             (pready),
    .prdata             (prdata),
    .pslverr            (pslverr),
    .external_count_pin (ext_pin),
    .compare_output_a   (oc_a),
    .compare_output_b   (oc_b),
    .irq_overflow       (irq[0]),
    .irq_compare_a      (irq[1]),
    .irq_compare_b      (irq[2]),
    .ack_overflow       (ack[0]),
    .ack_compare_a      (ack[1]),
    .ack_compare_b      (ack[2])
  );
  // ----------------------------------------
  // Common tasks
  // ----------------------------------------
  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      close_out();
    end
  end
  task automatic chk(string w, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", w, exp, seen);
    end
  endtask
  // Idle edge first, so back-to-back calls never drive psel twice in one step
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // No assumed wait count: only the bench ceiling ends a stuck transfer
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(string w, logic [11:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(w, rd, e);
  endtask
  task automatic pulse(int i);
    ack[i] <= 1'b1;
    @(posedge pclk);
    ack[i] <= 1'b0;
    @(posedge pclk);
  endtask
  // Start write, n idle edges and stop write give exactly n + 3 ticks at one per clock
  task automatic run(int n);
    wr(12'h004, 32'h1);
    repeat (n) @(posedge pclk);
    wr(12'h004, 32'h0);
    repeat (4) @(posedge pclk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_basic();
    for (int a = 0; a < 32; a += 4)
      rdc("reset value", a[11:0], 32'h0);
    chk("oc reset", {oc_b, oc_a}, 32'h0);
    for (int a = 8; a <= 16; a += 4)
    begin
      wr(a[11:0], 32'hffff_ff5a);
      rdc("reg rw", a[11:0], 32'h5a);
    end
    wr(12'h004, 32'hc0);
    rdc("strobe read", 12'h004, 32'h0);
    chk("no action", {oc_b, oc_a}, 32'h0);
    wr(12'h020, 32'hff);
    rdc("unmapped", 12'h020, 32'h0);
    $display("basic test done");
  endtask
  task automatic t_ext();
    wr(12'h008, 32'h0);
    for (int s = 7; s >= 6; s--)
    begin
      wr(12'h004, s);
      repeat (3)
      begin
        ext_pin <= 1'b1;
        repeat (6) @(posedge pclk);
        ext_pin <= 1'b0;
        repeat (6) @(posedge pclk);
      end
      wr(12'h004, 32'h0);
      repeat (4) @(posedge pclk);
      rdc("ext count", 12'h008, 3 * (8 - s));
    end
    repeat (20) @(posedge pclk);
    rdc("stopped", 12'h008, 32'h6);
    $display("ext test done");
  endtask
  task automatic t_ovf();
    wr(12'h018, 32'h7);
    wr(12'h014, 32'h1);
    wr(12'h008, 32'hfa);
    run(10);
    rdc("ovf flag", 12'h018, 32'h1);
    chk("ovf irq", irq, 32'h1);
    pulse(0);
    rdc("ovf ack", 12'h018, 32'h0);
    $display("overflow test done");
  endtask
  task automatic t_cmp();
    wr(12'h00c, 32'h20);
    wr(12'h010, 32'h22);
    wr(12'h008, 32'h1c);
    wr(12'h018, 32'h7);
    wr(12'h014, 32'h6);
    run(10);
    rdc("match flags", 12'h018, 32'h6);
    chk("cmp irq", irq, 32'h6);
    wr(12'h018, 32'h2);
    rdc("w1c", 12'h018, 32'h4);
    pulse(2);
    rdc("cmp ack", 12'h018, 32'h0);
    wr(12'h00c, 32'h40);
    wr(12'h008, 32'h40);
    repeat (3) @(posedge pclk);
    run(6);
    rdc("blocked", 12'h018, 32'h0);
    $display("compare test done");
  endtask
  task automatic t_mode();
    wr(12'h000, 32'h2);
    wr(12'h00c, 32'h05);
    wr(12'h008, 32'h0);
    wr(12'h018, 32'h7);
    run(40);
    apb(1'b0, 12'h008, 32'h0);
    chk("ctc top", rd <= 32'h5, 32'h1);
    rdc("ctc flag", 12'h018, 32'h2);
    wr(12'h000, 32'h0);
    wr(12'h00c, 32'h80);
    wr(12'h000, 32'h3);
    wr(12'h00c, 32'h22);
    rdc("buffer read", 12'h00c, 32'h22);
    wr(12'h008, 32'h10);
    wr(12'h018, 32'h7);
    run(20);
    apb(1'b0, 12'h018, 32'h0);
    chk("no early load", rd[1], 32'h0);
    // Wrap through bottom, then leave PWM so the read shows the active value
    wr(12'h008, 32'hf0);
    run(20);
    wr(12'h000, 32'h0);
    rdc("load at bottom", 12'h00c, 32'h22);
    $display("mode test done");
  endtask
  task automatic t_force();
    wr(12'h000, 32'h40);
    wr(12'h018, 32'h7);
    wr(12'h004, 32'h80);
    repeat (2) @(posedge pclk);
    chk("force a", oc_a, 32'h1);
    rdc("force no flag", 12'h018, 32'h0);
    wr(12'h000, 32'h43);
    chk("mode keep", oc_a, 32'h1);
    wr(12'h000, 32'h50);
    wr(12'h004, 32'hc0);
    repeat (2) @(posedge pclk);
    chk("action now", {oc_b, oc_a}, 32'h2);
    $display("force test done");
  endtask
  // Counter write while ticking every clock: the write wins, then one tick before capture
  task automatic t_live();
    wr(12'h004, 32'h1);
    wr(12'h008, 32'h80);
    rdc("live count", 12'h008, 32'h81);
    wr(12'h004, 32'h0);
    $display("live write test done");
  endtask
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_basic();
    t_ext();
    t_ovf();
    t_cmp();
    t_mode();
    t_force();
    t_live();
    close_out();
  end
endmodule
